//--- pewp_host.sv
// host controller driving a byte-wide parallel eeprom through its pins
//
// Overview of operation
// - writes drive data only with gate high
// - page bits stay fixed during a load
// - gate held high across every write pulse
// - next byte issued inside the load window
// - one to sixty-four bytes follow a sequence; none follow a protect sequence sent with cmd_last high
// - page fixed after unlock bytes
// - each status read is a fresh gate pulse
// - no assumed level of the alternating line
// - status reads reuse one fixed address
// - commands are 8-bit data, 13-bit address
module pewp_host #(
  parameter int unsigned BLC_CYC       = pewp_pkg::BLC_CYC_DEF,  // load window cycles
  parameter int unsigned WC_CYC        = pewp_pkg::WC_CYC_DEF,   // program timeout cycles
  parameter int unsigned TMR_W         = 19,                     // long timer width
  parameter logic [38:0] PROT_ON_ADDR  = '0,                     // three 13-bit addresses
  parameter logic [23:0] PROT_ON_DATA  = '0,                     // three command bytes
  parameter logic [77:0] PROT_OFF_ADDR = '0,                     // six 13-bit addresses
  parameter logic [47:0] PROT_OFF_DATA = '0                      // six command bytes
) (
  input  wire logic              clk_sys,          // system clock
  input  wire logic              reset,            // async reset, active high
  input  wire logic              clk_en,           // freezes all state while low
  input  wire logic              cmd_valid,        // command offered
  output logic                   cmd_ready,        // command taken when both high
  input  wire pewp_pkg::pewp_op_t cmd_op,          // command kind
  input  wire logic [12:0]       cmd_addr,         // byte address
  input  wire logic [7:0]        cmd_wdata,        // write byte
  input  wire logic              cmd_last,         // ends the page load
  input  wire logic              cmd_unlock,       // prefix a write with the unlock bytes
  input  wire logic              poll_toggle,      // 1 toggle polling, 0 data polling once a user byte is written (protect sequences with no user byte always toggle)
  output logic                   rsp_valid,        // one-cycle answer pulse
  output logic [7:0]             rsp_rdata,        // read byte or last status sample
  output logic                   rsp_err,          // program cycle timed out
  output logic                   busy,             // controller not idle
  output logic                   mem_ce_n,         // chip select, active low
  output logic                   mem_oe_n,         // output gate, active low
  output logic                   mem_we_n,         // write strobe, active low
  output logic                   mem_erase_hv_en,  // raise gate to elevated_erase_level
  output logic [12:0]            mem_addr,         // address pins
  output logic [7:0]             mem_dq_o,         // data pins, driven value
  output logic                   mem_dq_oe,        // data pins driven when high
  input  wire logic [7:0]        mem_dq_i          // data pins, sensed value
);
  import pewp_pkg::*;

  // ******************************
  // state and storage
  // ******************************
  typedef enum {
    ST_IDLE, ST_DISPATCH, ST_RD_ACT, ST_RD_REC, ST_WR_PULSE, ST_WR_HOLD,
    ST_LOAD_GAP, ST_LOAD_CLOSE, ST_POLL_ACT, ST_POLL_REC, ST_ER_PULSE
  } pewp_state_t;

  pewp_state_t state_q, state_d;
  pewp_op_t    op_q, op_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [12:0] addr_q, addr_d, last_addr_q, last_addr_d, mem_addr_d;
  logic [7:0]  wdata_q, wdata_d, last_data_q, last_data_d, mem_dq_o_d;
  logic [7:0]  dq_s1_q, dq_s2_q, rsp_rdata_d;
  logic [6:0]  page_q, page_d;
  logic [2:0]  seq_idx_q, seq_idx_d;
  logic        last_q, last_d, unlock_q, unlock_d, pend_q, pend_d;
  logic        seq_act_q, seq_act_d, seq_off_q, seq_off_d, data_pend_q, data_pend_d;
  logic        page_set_q, page_set_d, user_data_q, user_data_d;
  logic        have_prev_q, have_prev_d, prev_poll_q, prev_poll_d, prev_alt_q, prev_alt_d;
  logic        cmd_ready_d, rsp_valid_d, rsp_err_d, busy_d;
  logic        ce_n_d, oe_n_d, we_n_d, hv_d, dq_oe_d;
  logic        take, launch, gap_load, wait_load, gap_exp, wait_exp;
  logic        poll_ok, use_toggle;
  logic [20:0] seq_word;
  logic [7:0]  smp;

  // address and data of one protect sequence entry
  function automatic logic [20:0] seq_entry(input logic off, input logic [2:0] idx);
    if (off) begin
      seq_entry = {PROT_OFF_ADDR[idx*13 +: 13], PROT_OFF_DATA[idx*8 +: 8]};
    end else begin
      seq_entry = {PROT_ON_ADDR[idx*13 +: 13], PROT_ON_DATA[idx*8 +: 8]};
    end
  endfunction : seq_entry

  // ******************************
  // load window and program timers
  // ******************************
  pewp_timer #(.WIDTH(TMR_W)) u_gap_tmr (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .clk_en   (clk_en),
    .load     (gap_load),
    .load_val (TMR_W'(BLC_CYC - BLC_GUARD_CYC)),
    .expired  (gap_exp)
  );

  pewp_timer #(.WIDTH(TMR_W)) u_wait_tmr (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .clk_en   (clk_en),
    .load     (wait_load),
    .load_val (TMR_W'(WC_CYC)),
    .expired  (wait_exp)
  );

  // ******************************
  // sequencer next state
  // ******************************
  always_comb begin
    state_d = state_q;   op_d = op_q;           cnt_d = cnt_q;
    addr_d = addr_q;     wdata_d = wdata_q;     last_d = last_q;
    unlock_d = unlock_q; pend_d = pend_q;       page_d = page_q;
    seq_idx_d = seq_idx_q; seq_act_d = seq_act_q; seq_off_d = seq_off_q;
    data_pend_d = data_pend_q; page_set_d = page_set_q; user_data_d = user_data_q;
    last_addr_d = last_addr_q; last_data_d = last_data_q;
    have_prev_d = have_prev_q; prev_poll_d = prev_poll_q; prev_alt_d = prev_alt_q;
    mem_addr_d = mem_addr;  mem_dq_o_d = mem_dq_o;  rsp_rdata_d = rsp_rdata;
    rsp_valid_d = 1'b0;  rsp_err_d = rsp_err;
    take = 1'b0; launch = 1'b0; gap_load = 1'b0; wait_load = 1'b0;
    smp = dq_s2_q;
    use_toggle = poll_toggle || !user_data_q;   // sequence bytes are never stored
    seq_word = '0;
    poll_ok = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (pend_q) begin
          pend_d = 1'b0;
          state_d = ST_DISPATCH;
        end else if (cmd_valid && cmd_ready) begin
          take = 1'b1;
          state_d = ST_DISPATCH;
        end
      end
      ST_DISPATCH: begin
        page_set_d = 1'b0;
        user_data_d = 1'b0;
        unique case (op_q)
          PEWP_OP_READ: begin
            state_d = ST_RD_ACT;
            cnt_d = SAMPLE_CYC;
            mem_addr_d = addr_q;
          end
          PEWP_OP_WRITE: begin
            launch = 1'b1;
            data_pend_d = 1'b1;
            seq_act_d = unlock_q;
            seq_off_d = 1'b0;
            seq_idx_d = '0;
          end
          PEWP_OP_PROT_ON, PEWP_OP_PROT_OFF: begin
            launch = 1'b1;
            data_pend_d = 1'b0;
            seq_act_d = 1'b1;
            seq_off_d = (op_q == PEWP_OP_PROT_OFF);
            seq_idx_d = '0;
          end
          PEWP_OP_ERASE: begin
            state_d = ST_ER_PULSE;
            wait_load = 1'b1;
          end
        endcase
      end
      ST_RD_ACT: begin
        if (cnt_q == '0) begin
          rsp_rdata_d = smp;
          rsp_valid_d = 1'b1;
          rsp_err_d = 1'b0;
          state_d = ST_RD_REC;
          cnt_d = OEHP_CYC;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      ST_RD_REC: begin
        if (cnt_q == '0) begin
          state_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      ST_WR_PULSE: begin
        if (cnt_q == '0) begin
          state_d = ST_WR_HOLD;
          cnt_d = HOLD_CYC;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      ST_WR_HOLD: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 4'h1;
        end else if (seq_act_q && seq_idx_q != (seq_off_q ? PROT_OFF_LEN : PROT_ON_LEN) - 3'd1)
        begin
          seq_idx_d = seq_idx_q + 3'd1;
          launch = 1'b1;
        end else if (seq_act_q && data_pend_q) begin
          seq_act_d = 1'b0;
          launch = 1'b1;
        end else begin
          seq_act_d = 1'b0;
          gap_load = 1'b1;
          state_d = last_q ? ST_LOAD_CLOSE : ST_LOAD_GAP;
        end
      end
      ST_LOAD_GAP: begin
        if (cmd_valid && cmd_ready) begin
          take = 1'b1;
          if (cmd_op == PEWP_OP_WRITE && (!page_set_q || cmd_addr[12:6] == page_q)) begin
            launch = 1'b1;
          end else begin
            pend_d = 1'b1;
            state_d = ST_LOAD_CLOSE;
          end
        end else if (gap_exp) begin
          state_d = ST_LOAD_CLOSE;
        end
      end
      ST_LOAD_CLOSE: begin
        if (gap_exp) begin
          wait_load = 1'b1;
          have_prev_d = 1'b0;
          state_d = ST_POLL_ACT;
          cnt_d = SAMPLE_CYC;
          mem_addr_d = last_addr_q;
        end
      end
      ST_POLL_ACT: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 4'h1;
        end else begin
          if (use_toggle) begin
            poll_ok = have_prev_q && (smp[ALT_BIT] == prev_alt_q);
          end else begin
            poll_ok = have_prev_q && (smp[POLL_BIT] == last_data_q[POLL_BIT])
                      && (prev_poll_q == last_data_q[POLL_BIT]);
          end
          have_prev_d = 1'b1;
          prev_alt_d = smp[ALT_BIT];
          prev_poll_d = smp[POLL_BIT];
          cnt_d = OEHP_CYC;
          if (poll_ok || wait_exp) begin
            rsp_valid_d = 1'b1;
            rsp_rdata_d = smp;
            rsp_err_d = !poll_ok;
            state_d = ST_RD_REC;
          end else begin
            state_d = ST_POLL_REC;
          end
        end
      end
      ST_POLL_REC: begin
        if (cnt_q == '0) begin
          state_d = ST_POLL_ACT;
          cnt_d = SAMPLE_CYC;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      ST_ER_PULSE: begin
        if (wait_exp) begin
          rsp_valid_d = 1'b1;
          rsp_err_d = 1'b0;
          state_d = ST_RD_REC;
          cnt_d = HOLD_CYC;
        end
      end
    endcase
    // latch an accepted command
    if (take) begin
      op_d = cmd_op;
      addr_d = cmd_addr;
      wdata_d = cmd_wdata;
      last_d = cmd_last;
      unlock_d = cmd_unlock;
    end
    // start one write pulse from the sequence table or the user byte
    if (launch) begin
      state_d = ST_WR_PULSE;
      cnt_d = WP_CYC;
      if (seq_act_d) begin
        seq_word = seq_entry(seq_off_d, seq_idx_d);
        mem_addr_d = seq_word[20:8];
        mem_dq_o_d = seq_word[7:0];
      end else begin
        mem_addr_d = addr_d;
        mem_dq_o_d = wdata_d;
        data_pend_d = 1'b0;
        last_addr_d = addr_d;
        last_data_d = wdata_d;
        user_data_d = 1'b1;
        page_set_d = 1'b1;
        page_d = addr_d[12:6];
      end
    end
    // pin levels for the coming state
    ce_n_d = !(state_d inside {ST_RD_ACT, ST_WR_PULSE, ST_POLL_ACT, ST_ER_PULSE});
    oe_n_d = !(state_d inside {ST_RD_ACT, ST_POLL_ACT});
    we_n_d = !(state_d inside {ST_WR_PULSE, ST_ER_PULSE});
    hv_d = (state_d == ST_ER_PULSE);
    dq_oe_d = (state_d inside {ST_WR_PULSE, ST_WR_HOLD});
    cmd_ready_d = (state_d == ST_IDLE && !pend_d) || state_d == ST_LOAD_GAP;
    busy_d = (state_d != ST_IDLE) || pend_d;
  end

  // ******************************
  // registers and data synchroniser
  // ******************************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;   op_q <= PEWP_OP_READ;  cnt_q <= '0;
      addr_q <= '0;  wdata_q <= '0;  last_q <= 1'b0;  unlock_q <= 1'b0;  pend_q <= 1'b0;
      page_q <= '0;  seq_idx_q <= '0;  seq_act_q <= 1'b0;  seq_off_q <= 1'b0;
      data_pend_q <= 1'b0;  page_set_q <= 1'b0;  user_data_q <= 1'b0;
      last_addr_q <= '0;  last_data_q <= '0;
      have_prev_q <= 1'b0;  prev_poll_q <= 1'b0;  prev_alt_q <= 1'b0;
      dq_s1_q <= '0;  dq_s2_q <= '0;
      cmd_ready <= 1'b0;  rsp_valid <= 1'b0;  rsp_rdata <= '0;  rsp_err <= 1'b0;
      busy <= 1'b0;  mem_ce_n <= 1'b1;  mem_oe_n <= 1'b1;  mem_we_n <= 1'b1;
      mem_erase_hv_en <= 1'b0;  mem_addr <= '0;  mem_dq_o <= '0;  mem_dq_oe <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;   op_q <= op_d;  cnt_q <= cnt_d;
      addr_q <= addr_d;  wdata_q <= wdata_d;  last_q <= last_d;  unlock_q <= unlock_d;
      pend_q <= pend_d;  page_q <= page_d;  seq_idx_q <= seq_idx_d;
      seq_act_q <= seq_act_d;  seq_off_q <= seq_off_d;  data_pend_q <= data_pend_d;
      page_set_q <= page_set_d;  user_data_q <= user_data_d;
      last_addr_q <= last_addr_d;  last_data_q <= last_data_d;
      have_prev_q <= have_prev_d;  prev_poll_q <= prev_poll_d;  prev_alt_q <= prev_alt_d;
      dq_s1_q <= mem_dq_i;
      dq_s2_q <= dq_s1_q;
      cmd_ready <= cmd_ready_d;  rsp_valid <= rsp_valid_d;  rsp_rdata <= rsp_rdata_d;
      rsp_err <= rsp_err_d;  busy <= busy_d;
      mem_ce_n <= ce_n_d;  mem_oe_n <= oe_n_d;  mem_we_n <= we_n_d;
      mem_erase_hv_en <= hv_d;  mem_addr <= mem_addr_d;  mem_dq_o <= mem_dq_o_d;
      mem_dq_oe <= dq_oe_d;
    end
  end

endmodule : pewp_host

//--- pewp_host_monitor.sv
// assertion checker on the pins and command port of the eeprom host
module pewp_host_monitor #(
  parameter int unsigned WC_CYC = 300  // program timeout cycles
) (
  input wire logic               clk_sys,          // system clock
  input wire logic               reset,            // async reset
  input wire logic               cmd_valid,        // command offered
  input wire logic               cmd_ready,        // command accepted
  input wire pewp_pkg::pewp_op_t cmd_op,           // command kind
  input wire logic               busy,             // host not idle
  input wire logic               rsp_valid,        // answer pulse
  input wire logic               mem_ce_n,         // chip select
  input wire logic               mem_oe_n,         // output gate
  input wire logic               mem_we_n,         // write strobe
  input wire logic               mem_erase_hv_en,  // elevated gate
  input wire logic [12:0]        mem_addr,         // address pins
  input wire logic               mem_dq_oe         // data drive enable
);
  import pewp_pkg::*;
  localparam int ER_HI = WC_CYC + 40;
  // ******************************
  // pin protocol and answer timing properties
  // ******************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  gate_low_quiet_a : assert property (mem_dq_oe |-> mem_oe_n)
    else $error("data driven while gate low");
  strobe_gate_high_a : assert property (!mem_we_n |-> mem_oe_n)
    else $error("strobe low with gate low");
  strobe_needs_sel_a : assert property (!mem_we_n |-> !mem_ce_n)
    else $error("strobe low without select");
  erase_quiet_a : assert property (mem_erase_hv_en |-> mem_oe_n && !mem_dq_oe)
    else $error("erase with data or gate driven");
  write_width_a : assert property ($fell(mem_we_n) |-> !mem_we_n [*4])
    else $error("write pulse too short");
  addr_steady_a : assert property (!mem_ce_n && !$past(mem_ce_n) |-> $stable(mem_addr))
    else $error("address moved during select");
  read_width_a : assert property ($fell(mem_oe_n) |-> !mem_oe_n [*8])
    else $error("read pulse too short");
  gate_recover_a : assert property ($rose(mem_oe_n) |-> mem_oe_n [*6])
    else $error("gate high time too short");
  read_latency_a : assert property (cmd_valid && cmd_ready && !busy &&
    cmd_op == PEWP_OP_READ |-> ##10 rsp_valid) else $error("read answer late");
  erase_bound_a : assert property (cmd_valid && cmd_ready && !busy &&
    cmd_op == PEWP_OP_ERASE |-> ##[1:ER_HI] rsp_valid) else $error("erase answer late");
endmodule : pewp_host_monitor

bind pewp_host pewp_host_monitor #(.WC_CYC(WC_CYC)) pewp_host_monitor_inst (
  .clk_sys(clk_sys), .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_op(cmd_op), .busy(busy), .rsp_valid(rsp_valid), .mem_ce_n(mem_ce_n),
  .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n), .mem_erase_hv_en(mem_erase_hv_en),
  .mem_addr(mem_addr), .mem_dq_oe(mem_dq_oe));

//--- pewp_host_tb.sv
// self-checking bench for the parallel eeprom host controller
module pewp_host_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pewp_pkg::*;
  // sequence codes below are arbitrary
  localparam logic [38:0] ON_A  = {13'h0789, 13'h0456, 13'h0123};
  localparam logic [23:0] ON_D  = {8'h33, 8'h22, 8'h11};
  localparam logic [77:0] OFF_A = {13'h0def, 13'h0abc, 13'h0321, ON_A};
  localparam logic [47:0] OFF_D = {8'h66, 8'h55, 8'h44, ON_D};
  logic        clk_sys, reset, clk_en, cmd_valid, cmd_ready, cmd_last, cmd_unlock;
  logic        poll_toggle, rsp_valid, rsp_err, busy, ce_n, oe_n, we_n, hv, dq_oe, er;
  logic [12:0] cmd_addr, mem_addr;
  logic [7:0]  cmd_wdata, rsp_rdata, dq_o, dev_dq, rd;
  logic [19:0] prog_cyc;
  pewp_op_t    cmd_op;
  int          bad_count, comparisons;
  wire logic [7:0] dq_pin = dq_oe ? dq_o : dev_dq;
  pewp_host #(.BLC_CYC(40), .WC_CYC(300), .PROT_ON_ADDR(ON_A), .PROT_ON_DATA(ON_D),
    .PROT_OFF_ADDR(OFF_A), .PROT_OFF_DATA(OFF_D)) pewp_host_inst (
    .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_last(cmd_last), .cmd_unlock(cmd_unlock), .poll_toggle(poll_toggle),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err), .busy(busy),
    .mem_ce_n(ce_n), .mem_oe_n(oe_n), .mem_we_n(we_n), .mem_erase_hv_en(hv),
    .mem_addr(mem_addr), .mem_dq_o(dq_o), .mem_dq_oe(dq_oe), .mem_dq_i(dq_pin));
  pewp_mem_model #(.ON_A(ON_A), .ON_D(ON_D), .OFF_A(OFF_A), .OFF_D(OFF_D), .BLC(30))
    pewp_mem_model_inst (.clk_sys(clk_sys), .prog_cyc(prog_cyc), .mem_ce_n(ce_n),
    .mem_oe_n(oe_n), .mem_we_n(we_n), .mem_erase_hv_en(hv), .mem_addr(mem_addr),
    .mem_dq_o(dq_o), .mem_dq_oe(dq_oe), .dev_dq(dev_dq));
  // ******************************
  // shared tasks
  // ******************************
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic close_out();
    if (bad_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // bounded wait for a flag seen high at a clock edge
  task automatic wait_for(const ref logic flag);
    int n;
    n = 0;
    @(posedge clk_sys);
    while (flag !== 1'b1 && n < 30000) begin
      n++;
      @(posedge clk_sys);
    end
    if (n >= 30000) begin
      bad_count++;
      close_out();
    end
  endtask : wait_for
  // offer a command one edge on, hold it until taken
  task automatic send(input pewp_op_t op, input logic [12:0] a, input logic [7:0] d,
                      input logic l, input logic u);
    @(posedge clk_sys);
    #2;
    {cmd_op, cmd_addr, cmd_wdata, cmd_last, cmd_unlock, cmd_valid} = {op, a, d, l, u, 1'b1};
    wait_for(cmd_ready);
    #2;
    cmd_valid = 1'b0;
  endtask : send
  // take what the answer pulse carries
  task automatic get_rsp();
    wait_for(rsp_valid);
    {rd, er} = {rsp_rdata, rsp_err};
    #2;
  endtask : get_rsp
  task automatic rd_byte(input logic [12:0] a);
    send(PEWP_OP_READ, a, 8'h00, 1'b0, 1'b0);
    get_rsp();
  endtask : rd_byte
  task automatic wr_one(input logic [12:0] a, input logic [7:0] d, input logic u);
    send(PEWP_OP_WRITE, a, d, 1'b1, u);
    get_rsp();
  endtask : wr_one
  // ******************************
  // scenarios
  // ******************************
  task automatic s_page();
    poll_toggle = 1'b0;
    send(PEWP_OP_WRITE, 13'h0040, 8'h81, 1'b0, 1'b0);
    send(PEWP_OP_WRITE, 13'h007f, 8'h7e, 1'b0, 1'b0);
    send(PEWP_OP_WRITE, 13'h0041, 8'h00, 1'b1, 1'b0);
    get_rsp();
    check(8'(er), 8'h00);
    rd_byte(13'h0040);
    check(rd, 8'h81);
    rd_byte(13'h007f);
    check(rd, 8'h7e);
    rd_byte(13'h0041);
    check(rd, 8'h00);
  endtask : s_page
  task automatic s_window();
    poll_toggle = 1'b1;
    send(PEWP_OP_WRITE, 13'h1fff, 8'hc3, 1'b0, 1'b0);
    get_rsp();
    check(8'(er), 8'h00);
    rd_byte(13'h1fff);
    check(rd, 8'hc3);
  endtask : s_window
  task automatic s_protect();
    poll_toggle = 1'b1;
    send(PEWP_OP_PROT_ON, 13'h0000, 8'h00, 1'b1, 1'b0);
    get_rsp();
    check(8'(er), 8'h00);
    wr_one(13'h0100, 8'h5a, 1'b0);
    rd_byte(13'h0100);
    check(rd, 8'hff);
    wr_one(13'h0100, 8'h3c, 1'b1);
    rd_byte(13'h0100);
    check(rd, 8'h3c);
    send(PEWP_OP_PROT_OFF, 13'h0000, 8'h00, 1'b1, 1'b0);
    get_rsp();
    wr_one(13'h0101, 8'h77, 1'b0);
    rd_byte(13'h0101);
    check(rd, 8'h77);
  endtask : s_protect
  task automatic s_slow();
    prog_cyc = 20'h0_0190;
    wr_one(13'h0200, 8'ha5, 1'b0);
    check(8'(er), 8'h01);
    repeat (200) @(posedge clk_sys);
    #2;
    prog_cyc = 20'h0_0064;
    rd_byte(13'h0200);
    check(rd, 8'ha5);
  endtask : s_slow
  task automatic s_erase();
    send(PEWP_OP_ERASE, 13'h0000, 8'h00, 1'b0, 1'b0);
    get_rsp();
    check(8'(er), 8'h00);
    rd_byte(13'h0040);
    check(rd, 8'hff);
  endtask : s_erase
  // reset, run every scenario, report
  initial begin
    {reset, clk_en, cmd_valid, cmd_last, cmd_unlock, poll_toggle} = 6'b110000;
    {cmd_addr, cmd_wdata, bad_count, comparisons} = '0;
    cmd_op = PEWP_OP_READ;
    prog_cyc = 20'h0_0064;
    repeat (6) @(posedge clk_sys);
    #2;
    reset = 1'b0;
    @(posedge clk_sys);
    #2;
    check({ce_n, oe_n, we_n, dq_oe, hv, 3'h0}, 8'he0);
    s_page();
    s_window();
    s_protect();
    s_slow();
    s_erase();
    close_out();
  end
endmodule : pewp_host_tb

//--- pewp_mem_model.sv
// behavioural model of the byte-wide eeprom facing the host
module pewp_mem_model #(
  parameter logic [38:0] ON_A  = '0,  // enable sequence addresses
  parameter logic [23:0] ON_D  = '0,  // enable sequence bytes
  parameter logic [77:0] OFF_A = '0,  // disable sequence addresses
  parameter logic [47:0] OFF_D = '0,  // disable sequence bytes
  parameter int unsigned BLC   = 40   // load window cycles
) (
  input  wire logic        clk_sys,          // system clock
  input  wire logic [19:0] prog_cyc,         // internal program time
  input  wire logic        mem_ce_n,         // chip select
  input  wire logic        mem_oe_n,         // output gate
  input  wire logic        mem_we_n,         // write strobe
  input  wire logic        mem_erase_hv_en,  // elevated gate
  input  wire logic [12:0] mem_addr,         // address pins
  input  wire logic [7:0]  mem_dq_o,         // host data
  input  wire logic        mem_dq_oe,        // host drives data
  output logic      [7:0]  dev_dq            // device data
);
  logic [7:0]  arr [8192];
  logic [12:0] qa [$];
  logic [7:0]  qd [$];
  logic [7:0]  last_d, cnt, d_p;
  logic [19:0] win, pg;
  logic [12:0] a_p;
  logic        prot, tgl, we_p, ce_p, oe_p, hv_p;
  // ******************************
  // load, program and protect state
  // ******************************
  function automatic logic seq_hit(input logic off, input int n);
    seq_hit = qa.size() >= n;
    for (int i = 0; i < n; i++)
      if (seq_hit) seq_hit = off ? (qa[i] == OFF_A[i*13+:13] && qd[i] == OFF_D[i*8+:8])
                                 : (qa[i] == ON_A[i*13+:13] && qd[i] == ON_D[i*8+:8]);
  endfunction : seq_hit
  // end of program: update protection, store unless locked
  task automatic commit();
    int k;
    k = prot ? qa.size() : 0;
    if (seq_hit(1'b1, 6)) begin
      prot = 1'b0;
      k = 6;
    end else if (seq_hit(1'b0, 3)) begin
      prot = 1'b1;
      k = 3;
    end
    for (int i = k; i < qa.size(); i++) arr[qa[i]] = qd[i];
    qa.delete();
    qd.delete();
  endtask : commit
  initial begin
    {prot, tgl, hv_p, win, pg, cnt, a_p, d_p, last_d} = '0;
    {we_p, ce_p, oe_p} = 3'b111;
    foreach (arr[i]) arr[i] = 8'hff;
  end
  // pins sampled at the falling clock edge, away from host updates
  always @(negedge clk_sys) begin
    if (!we_p && mem_we_n && !ce_p && oe_p && !hv_p && pg == 0) begin
      qa.push_back(a_p);
      qd.push_back(d_p);
      last_d = d_p;
      win = 20'(BLC);
    end else if (win != 0) begin
      win = win - 1;
      if (win == 0) pg = prog_cyc;
    end else if (pg != 0) begin
      pg = pg - 1;
      if (pg == 0) commit();
    end
    if ((ce_p || oe_p) && !mem_ce_n && !mem_oe_n) tgl = ~tgl;
    if (hv_p && !mem_erase_hv_en) foreach (arr[i]) arr[i] = 8'hff;
    {we_p, ce_p, oe_p, hv_p} = {mem_we_n, mem_ce_n, mem_oe_n, mem_erase_hv_en};
    a_p = mem_addr;
    d_p = mem_dq_oe ? mem_dq_o : 8'hzz;
    cnt = cnt + 1;
  end
  // read data, status while programming, moving junk when released
  assign dev_dq = (!mem_ce_n && !mem_oe_n && mem_we_n)
                ? (pg != 0 ? {~last_d[7], tgl, arr[mem_addr][5:0]} : arr[mem_addr])
                : cnt;
endmodule : pewp_mem_model

//--- pewp_pkg.sv
// shared constants and command codes for the parallel eeprom page write host
package pewp_pkg;

  // ******************************
  // clock and bus geometry
  // ******************************
  localparam int unsigned CLK_PERIOD_NS = 25;    // clk_sys at 40 mhz
  localparam int unsigned ADDR_W        = 13;    // address lines
  localparam int unsigned DATA_W        = 8;     // data lines
  localparam int unsigned PAGE_LSB      = 6;     // lowest page_select_bits position
  localparam int unsigned POLL_BIT      = 7;     // poll_status_line position
  localparam int unsigned ALT_BIT       = 6;     // alternating_status_line position
  localparam int unsigned SYNC_STAGES   = 2;     // flops on the data input path

  // ******************************
  // pin timing, ns and cycles
  // ******************************
  localparam int unsigned WP_NS      = 100;      // least write pulse width
  localparam int unsigned WPH_NS     = 50;       // least pulse high and address hold
  localparam int unsigned ACC_NS     = 120;      // longest access delay, slowest grade
  localparam int unsigned OEHP_NS    = 150;      // least gate high between status reads
  localparam logic [3:0]  WP_CYC     = 4'((WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  HOLD_CYC   = 4'((WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  SAMPLE_CYC = 4'((ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
                                          + SYNC_STAGES);
  localparam logic [3:0]  OEHP_CYC   = 4'((OEHP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ******************************
  // long timer defaults
  // ******************************
  localparam int unsigned BLC_US        = 150;   // byte_load_window, longest
  localparam int unsigned WC_MS         = 10;    // program_cycle_time, longest
  localparam int unsigned BLC_CYC_DEF   = BLC_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned WC_CYC_DEF    = WC_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned BLC_GUARD_CYC = 8;     // margin for a byte taken at the limit

  // ******************************
  // protect sequence lengths
  // ******************************
  localparam logic [2:0] PROT_ON_LEN  = 3'd3;
  localparam logic [2:0] PROT_OFF_LEN = 3'd6;

  // ******************************
  // user commands
  // ******************************
  typedef enum logic [2:0] {
    PEWP_OP_READ,
    PEWP_OP_WRITE,
    PEWP_OP_PROT_ON,
    PEWP_OP_PROT_OFF,
    PEWP_OP_ERASE
  } pewp_op_t;

endpackage : pewp_pkg

//--- pewp_timer.sv
// down counter that flags expiry of a loaded cycle count
module pewp_timer #(
  parameter int unsigned WIDTH = 19
) (
  input  wire logic             clk_sys,   // system clock
  input  wire logic             reset,     // async reset, active high
  input  wire logic             clk_en,    // freezes the count while low
  input  wire logic             load,      // restart with load_val
  input  wire logic [WIDTH-1:0] load_val,  // cycles until expiry
  output logic                  expired    // count has reached zero
);

  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;

  // next count: load wins, otherwise run down to zero and stay
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = load_val;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // count register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
    end
  end

  assign expired = (cnt_q == '0);

endmodule : pewp_timer
